/* File: fbha_buf_model.sv */
// Purpose: buffer read port stand-in
// Assumes: data valid in the read strobe cycle
// Notes:   idle data is inverted so stale data never matches
`timescale 1ns/100ps
module fbha_buf_model
(
   input  wire        rd_en,
   input  wire [9:0]  x,
   input  wire [9:0]  y,
   input  wire        bottom,
   input  wire [1:0]  src,
   output wire [31:0] data
);
   // pattern names source, origin and position fetched
   wire [31:0] pat = {src, bottom, 1'b1, 8'hC3, y, x};
   assign data = rd_en ? pat : ~pat;
endmodule // fbha_buf_model

/* File: fbha_defines.vh */
// Purpose: constants for the pixel window access controller
// Assumes: plain port register access, 32-bit data
// Notes:   offsets are word addresses on the plain register port
`ifndef FBHA_DEFINES_VH
`define FBHA_DEFINES_VH
// register offsets
`define FBHA_OFS_ACCESS_CTRL  4'h0
`define FBHA_OFS_PIXEL_MODE   4'h1
`define FBHA_OFS_CONST_DA     4'h2
`define FBHA_OFS_STATUS       4'h3
// access control fields
`define FBHA_FMT_MSB          3
`define FBHA_FMT_LSB          0
`define FBHA_WSEL_MSB         5
`define FBHA_WSEL_LSB         4
`define FBHA_RSEL_MSB         7
`define FBHA_RSEL_LSB         6
`define FBHA_PIPE_BIT         8
`define FBHA_LANE_MSB         10
`define FBHA_LANE_LSB         9
`define FBHA_WSWAP_BIT        11
`define FBHA_WSWZ_BIT         12
`define FBHA_YORG_BIT         13
`define FBHA_WSRC_BIT         14
`define FBHA_RSWAP_BIT        15
`define FBHA_RSWZ_BIT         16
`define FBHA_CTRL_W           17
// pixel mode fields
`define FBHA_PM_CMASK_BIT     9
`define FBHA_PM_ZMASK_BIT     10
`define FBHA_PM_YORG_BIT      17
`define FBHA_PM_ABUF_BIT      18
// reset values
`define FBHA_CTRL_RST         17'h00000
`define FBHA_PM_RST           32'h00000000
`define FBHA_CDA_RST          32'h00000000
// write format codes
`define FBHA_F_565            4'h0
`define FBHA_F_555            4'h1
`define FBHA_F_1555           4'h2
`define FBHA_F_888            4'h4
`define FBHA_F_8888           4'h5
`define FBHA_F_Z565           4'hC
`define FBHA_F_Z555           4'hD
`define FBHA_F_Z1555          4'hE
`define FBHA_F_ZZ             4'hF
`endif

/* File: fbha_top.v */
// Purpose: host pixel window access: write decode, routing and read return
// Assumes: one clock, inputs synchronous, buffers behind a single-cycle port
// Notes:   each accepted write yields one beat one cycle later, a pixel pair only for 16-bit colour and depth-pair formats
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps
`include "fbha_defines.vh"

module fbha_top
#(
   parameter XW = 10,
   parameter YW = 10
)
(
   input  wire                ref_clk,
   input  wire                reset,
   input  wire [3:0]          reg_addr,
   input  wire [31:0]         reg_wdata,
   input  wire                reg_wr,
   input  wire                reg_rd,
   output reg  [31:0]         reg_rdata,
   input  wire [XW+YW-1:0]    win_offset,
   input  wire [31:0]         win_wdata,
   input  wire                win_wr,
   input  wire                win_rd,
   output reg  [31:0]         win_rdata,
   input  wire [31:0]         buf_rdata,
   output wire [XW-1:0]       buf_raddr_x,
   output wire [YW-1:0]       buf_raddr_y,
   output wire                buf_rd_origin_bottom,
   output wire [1:0]          buf_rd_src,
   output reg                 px_valid_ff,
   output reg                 px_to_pipe_ff,
   output reg  [1:0]          px_buf_ff,
   output reg  [XW-1:0]       px_x_ff,
   output reg  [YW-1:0]       px_y_ff,
   output reg                 px_origin_bottom_ff,
   output reg                 px_pair_ff,
   output reg  [31:0]         px_argb0_ff,
   output reg  [31:0]         px_argb1_ff,
   output reg  [15:0]         px_z0_ff,
   output reg  [15:0]         px_z1_ff,
   output reg                 px_col_we_ff,
   output reg                 px_z_we_ff,
   output reg                 px_a_we_ff,
   output reg  [47:0]         px_w_ff
);

   reg  [`FBHA_CTRL_W-1:0] ctrl_ff;
   reg  [31:0]             pmode_ff;
   reg  [31:0]             cda_ff;
   reg  [7:0]              drop_cnt_ff;

   wire [3:0] fmt     = ctrl_ff[`FBHA_FMT_MSB:`FBHA_FMT_LSB];
   wire [1:0] wsel    = ctrl_ff[`FBHA_WSEL_MSB:`FBHA_WSEL_LSB];
   wire [1:0] lane    = ctrl_ff[`FBHA_LANE_MSB:`FBHA_LANE_LSB];
   wire       pipe_en = ctrl_ff[`FBHA_PIPE_BIT];
   wire       abuf_en = pmode_ff[`FBHA_PM_ABUF_BIT];

   // format classes
   wire f16   = (fmt == `FBHA_F_565) | (fmt == `FBHA_F_555) | (fmt == `FBHA_F_1555);
   wire f32   = (fmt == `FBHA_F_888) | (fmt == `FBHA_F_8888);
   wire fz16  = (fmt == `FBHA_F_Z565) | (fmt == `FBHA_F_Z555) | (fmt == `FBHA_F_Z1555);
   wire fzz   = (fmt == `FBHA_F_ZZ);
   wire fmt_ok = f16 | f32 | fz16 | fzz;
   wire sel_ok = ~wsel[1];
   wire accept = win_wr & fmt_ok & sel_ok;

   // swizzle first, then word swap, then lanes; swap skipped for 32-bit colour
   wire [31:0] swz;
   wire [31:0] swp;
   wire        do_swap = ctrl_ff[`FBHA_WSWAP_BIT] & ~f32;
   fbha_byte_rev #(.NB(4)) i_fbha_byte_rev_wr
   (
      .d  (win_wdata),
      .en (ctrl_ff[`FBHA_WSWZ_BIT]),
      .q  (swz)
   );
   fbha_half_swap #(.HW(16)) i_fbha_half_swap_wr
   (
      .d  (swz),
      .en (do_swap),
      .q  (swp)
   );
   wire [15:0] hi  = swp[31:16];
   wire [15:0] lo  = swp[15:0];

   // 16-bit colour expand to 8-bit ARGB with lane order
   function [31:0] fbha_c16;
      input [15:0] d;
      input [3:0]  f;
      input [1:0]  ln;
      input [7:0]  ka;
      reg   [4:0]  c0, c2;
      reg   [5:0]  c1;
      reg          ab;
      reg   [7:0]  r, b, a;
      begin
         if (f[1:0] == 2'h0)
         begin
            c0 = d[15:11];
            c1 = d[10:5];
            c2 = d[4:0];
            ab = 1'b0;
         end
         else if (ln[1])
         begin
            c0 = d[15:11];
            c1 = {d[10:6], d[10]};
            c2 = d[5:1];
            ab = d[0];
         end
         else
         begin
            c0 = d[14:10];
            c1 = {d[9:5], d[9]};
            c2 = d[4:0];
            ab = d[15];
         end
         r = ln[0] ? {c2, c2[4:2]} : {c0, c0[4:2]};
         b = ln[0] ? {c0, c0[4:2]} : {c2, c2[4:2]};
         a = (f[1:0] == 2'h2) ? {8{ab}} : ka;
         fbha_c16 = {a, r, c1, c1[5:4], b};
      end
   endfunction

   // 32-bit colour with lane order
   function [31:0] fbha_c32;
      input [31:0] d;
      input [1:0]  ln;
      input        has_a;
      input [7:0]  ka;
      reg   [7:0]  a, x, g, y;
      begin
         if (ln[1])
         begin
            x = d[31:24];
            g = d[23:16];
            y = d[15:8];
            a = d[7:0];
         end
         else
         begin
            a = d[31:24];
            x = d[23:16];
            g = d[15:8];
            y = d[7:0];
         end
         fbha_c32 = {(has_a ? a : ka), (ln[0] ? y : x), g, (ln[0] ? x : y)};
      end
   endfunction

   wire [7:0]  k_a  = cda_ff[31:24];
   wire [15:0] k_z  = cda_ff[15:0];
   wire [15:0] cpx  = fz16 ? lo : 16'h0000;
   wire [15:0] wz   = fz16 ? hi : k_z;
   wire [31:0] col0 = f32 ? fbha_c32(swp, lane, (fmt == `FBHA_F_8888), k_a) :
                      fbha_c16(f16 ? lo : cpx, fmt, lane, k_a);
   wire [31:0] col1 = fbha_c16(hi, fmt, lane, k_a);
   wire        has_a = (fmt == `FBHA_F_1555) | (fmt == `FBHA_F_8888) |
                       (fmt == `FBHA_F_Z1555);

   // offset to screen position; x taken as given, not forced even for two-pixel formats
   wire [XW-1:0] off_x = win_offset[XW-1:0];
   wire [YW-1:0] off_y = win_offset[XW+YW-1:XW];

   // write beat register: routing decided here
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         px_valid_ff         <= 1'b0;
         px_to_pipe_ff       <= 1'b0;
         px_buf_ff           <= 2'h0;
         px_x_ff             <= {XW{1'b0}};
         px_y_ff             <= {YW{1'b0}};
         px_origin_bottom_ff <= 1'b0;
         px_pair_ff          <= 1'b0;
         px_argb0_ff         <= 32'h00000000;
         px_argb1_ff         <= 32'h00000000;
         px_z0_ff            <= 16'h0000;
         px_z1_ff            <= 16'h0000;
         px_col_we_ff        <= 1'b0;
         px_z_we_ff          <= 1'b0;
         px_a_we_ff          <= 1'b0;
         px_w_ff             <= 48'h000000000000;
      end
      else
      begin
         px_valid_ff   <= accept;
         px_to_pipe_ff <= pipe_en;
         px_buf_ff     <= wsel;
         px_x_ff       <= off_x;
         px_y_ff       <= off_y;
         // pipeline uses pixel mode origin, bypass uses access origin
         px_origin_bottom_ff <= pipe_en ? pmode_ff[`FBHA_PM_YORG_BIT] :
                                          ctrl_ff[`FBHA_YORG_BIT];
         px_pair_ff    <= f16 | fzz;
         // pixel 0 is the left pixel (low half after swap), pixel 1 the right
         px_argb0_ff   <= col0;
         px_argb1_ff   <= col1;
         px_z0_ff      <= fzz ? lo : wz;
         px_z1_ff      <= fzz ? hi : wz;
         if (pipe_en)
         begin
            // pipeline applies the pixel mode masks itself
            px_col_we_ff <= 1'b1;
            px_z_we_ff   <= 1'b1;
            px_a_we_ff   <= 1'b1;
            px_w_ff      <= {16'h0000, (ctrl_ff[`FBHA_WSRC_BIT] ? k_z :
                                        (fzz ? lo : wz)), 16'h0000};
         end
         else
         begin
            // masks of pixel mode ignored on purpose in bypass
            px_col_we_ff <= ~fzz;
            px_z_we_ff   <= fzz | (fz16 & ~((fmt == `FBHA_F_Z1555) & abuf_en));
            px_a_we_ff   <= has_a & abuf_en;
            px_w_ff      <= 48'h000000000000;
         end
      end
   end

   // read path: own swap and swizzle, write swizzle bit not used
   wire [31:0] rd_swp;
   wire [31:0] rd_swz;
   fbha_half_swap #(.HW(16)) i_fbha_half_swap_rd
   (
      .d  (buf_rdata),
      .en (ctrl_ff[`FBHA_RSWAP_BIT]),
      .q  (rd_swp)
   );
   fbha_byte_rev #(.NB(4)) i_fbha_byte_rev_rd
   (
      .d  (rd_swp),
      .en (ctrl_ff[`FBHA_RSWZ_BIT]),
      .q  (rd_swz)
   );
   assign buf_raddr_x          = off_x;
   assign buf_raddr_y          = off_y;
   assign buf_rd_origin_bottom = ctrl_ff[`FBHA_YORG_BIT];
   assign buf_rd_src           = ctrl_ff[`FBHA_RSEL_MSB:`FBHA_RSEL_LSB];

   // window read data: reserved read source returns zero
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         win_rdata <= 32'h00000000;
      else if (win_rd)
         win_rdata <= (buf_rd_src == 2'h3) ? 32'h00000000 : rd_swz;
   end

   // registers and dropped-write counter
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_ff     <= `FBHA_CTRL_RST;
         pmode_ff    <= `FBHA_PM_RST;
         cda_ff      <= `FBHA_CDA_RST;
         drop_cnt_ff <= 8'h00;
      end
      else
      begin
         if (reg_wr & (reg_addr == `FBHA_OFS_ACCESS_CTRL))
            ctrl_ff <= reg_wdata[`FBHA_CTRL_W-1:0];
         if (reg_wr & (reg_addr == `FBHA_OFS_PIXEL_MODE))
            pmode_ff <= reg_wdata;
         if (reg_wr & (reg_addr == `FBHA_OFS_CONST_DA))
            cda_ff <= reg_wdata;
         if (win_wr & ~accept & (drop_cnt_ff != 8'hFF))
            drop_cnt_ff <= drop_cnt_ff + 8'h01;
      end
   end

   // register read, one cycle later; unmapped reads as zero
   always @(posedge ref_clk or posedge reset)
   begin
      if (reset)
         reg_rdata <= 32'h00000000;
      else if (reg_rd)
      begin
         case (reg_addr)
            `FBHA_OFS_ACCESS_CTRL: reg_rdata <= {15'h0000, ctrl_ff};
            `FBHA_OFS_PIXEL_MODE:  reg_rdata <= pmode_ff;
            `FBHA_OFS_CONST_DA:    reg_rdata <= cda_ff;
            `FBHA_OFS_STATUS:      reg_rdata <= {22'h000000, ~sel_ok, ~fmt_ok, drop_cnt_ff};
            default:               reg_rdata <= 32'h00000000;
         endcase
      end
   end

endmodule // fbha_top

// byte order reversal, shared by the write and read data paths
module fbha_byte_rev
#(
   parameter NB = 4
)
(
   input  wire [8*NB-1:0] d,
   input  wire            en,
   output wire [8*NB-1:0] q
);

   wire [8*NB-1:0] rev;
   genvar          k;

   // byte k of the result is byte NB-1-k of the input
   generate
      for (k = 0; k < NB; k = k + 1)
      begin : g_byte
         assign rev[8*k +: 8] = d[8*(NB-1-k) +: 8];
      end
   endgenerate

   // a plain mux keeps the disabled path free of any reordering
   assign q = en ? rev : d;

endmodule // fbha_byte_rev

// half-word exchange; callers decide when it is allowed
module fbha_half_swap
#(
   parameter HW = 16
)
(
   input  wire [2*HW-1:0] d,
   input  wire            en,
   output wire [2*HW-1:0] q
);

   // upper and lower halves trade places when enabled
   assign q = en ? {d[HW-1:0], d[2*HW-1:HW]} : d;

endmodule // fbha_half_swap

/* File: fbha_top_chk.sv */
// Purpose: port checks for the pixel window controller
// Assumes: one clock; register contents not visible
// Notes:   ties beats and read returns to their strobes
`timescale 1ns/100ps
module fbha_top_chk
#(
   parameter XW = 10,
   parameter YW = 10
)
(
   input wire ref_clk, reset, win_wr, win_rd, px_valid_ff, px_to_pipe_ff,
   input wire px_pair_ff, px_col_we_ff, px_z_we_ff, px_a_we_ff,
   input wire [XW+YW-1:0] win_offset,
   input wire [31:0]      win_rdata,
   input wire [XW-1:0]    buf_raddr_x, px_x_ff,
   input wire [YW-1:0]    buf_raddr_y, px_y_ff,
   input wire [1:0]       buf_rd_src, px_buf_ff,
   input wire [47:0]      px_w_ff
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // beats split by route, since mask rules differ
   sequence s_px; px_valid_ff; endsequence
   sequence s_pipe; px_valid_ff && px_to_pipe_ff; endsequence
   sequence s_byp; px_valid_ff && !px_to_pipe_ff; endsequence
   sequence s_rsv; win_rd && buf_rd_src == 2'h3; endsequence
   property p_cause; s_px |-> $past(win_wr); endproperty
   property p_xy; s_px |-> {px_y_ff, px_x_ff} == $past(win_offset); endproperty
   property p_ra; win_rd |-> {buf_raddr_y, buf_raddr_x} == win_offset; endproperty
   property p_rsv; s_rsv |=> win_rdata == 32'h0; endproperty
   property p_pwe; s_pipe |-> px_col_we_ff && px_z_we_ff && px_a_we_ff; endproperty
   property p_w; s_pipe |-> px_w_ff[47:32] == 16'h0 && px_w_ff[15:0] == 16'h0; endproperty
   property p_za; s_byp |-> !(px_z_we_ff && px_a_we_ff); endproperty
   property p_some; s_byp |-> px_col_we_ff || px_z_we_ff; endproperty
   property p_zz; s_byp ##0 !px_col_we_ff |-> px_pair_ff; endproperty
   property p_buf; s_px |-> px_buf_ff <= 2'h1; endproperty
   a_cause: assert property (p_cause) else $error("beat with no write");
   a_xy: assert property (p_xy) else $error("beat position");
   a_ra: assert property (p_ra) else $error("read position");
   a_rsv: assert property (p_rsv) else $error("reserved source data");
   a_pwe: assert property (p_pwe) else $error("pipeline enables");
   a_w: assert property (p_w) else $error("w spare bits");
   a_za: assert property (p_za) else $error("depth and alpha both");
   a_some: assert property (p_some) else $error("bypass writes nothing");
   a_zz: assert property (p_zz) else $error("depth pair");
   a_buf: assert property (p_buf) else $error("reserved target");
endmodule // fbha_top_chk
bind fbha_top fbha_top_chk #(.XW(XW), .YW(YW)) i_fbha_top_chk (.*);

/* File: tb_fbha_top.sv */
// Purpose: self-checking bench for the pixel window controller
// Assumes: registers over the plain strobe port
// Notes:   seeded lfsr sweep plus hand-made corner cases
`timescale 1ns/100ps
`include "fbha_defines.vh"
module tb_fbha_top;
   localparam XW = 10;
   localparam YW = 10;
   // corner ctrl words: swizzle+swap, pipe depth pairs, fmt 14, reserved
   localparam [135:0] DC = {17'h0020, 17'h0003, 17'h0502, 17'h000E,
                            17'h000E, 17'h590F, 17'h190F, 17'h1E05};
   reg ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   reg win_wr = 1'b0, win_rd = 1'b0;
   reg [3:0] reg_addr = 4'h0;
   reg [31:0] reg_wdata = 32'h0, win_wdata = 32'h0;
   reg [19:0] win_offset = 20'h0;
   wire [31:0] reg_rdata, win_rdata, buf_rdata, px_argb0_ff, px_argb1_ff;
   wire [9:0] buf_raddr_x, px_x_ff, buf_raddr_y, px_y_ff;
   wire buf_rd_origin_bottom, px_valid_ff, px_to_pipe_ff, px_origin_bottom_ff;
   wire px_pair_ff, px_col_we_ff, px_z_we_ff, px_a_we_ff;
   wire [1:0] buf_rd_src, px_buf_ff;
   wire [15:0] px_z0_ff, px_z1_ff;
   wire [47:0] px_w_ff;
   reg [16:0] c_q;
   reg [31:0] p_q, k_q, rnd;
   integer bad_count = 0, compares = 0, drops = 0, i;
   fbha_top #(.XW(XW), .YW(YW)) i_fbha_top (.*);
   fbha_buf_model i_fbha_buf_model (.rd_en(win_rd), .x(buf_raddr_x), .y(buf_raddr_y),
      .bottom(buf_rd_origin_bottom), .src(buf_rd_src), .data(buf_rdata));
   initial forever #10 ref_clk = ~ref_clk;
   // a hang counts as a mismatch
   initial
   begin
      #1500000;
      bad_count = bad_count + 1;
      summarize;
   end
   function [31:0] lfsr(input [31:0] v);
      lfsr = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function [31:0] swz(input [31:0] v);
      swz = {v[7:0], v[15:8], v[23:16], v[31:24]};
   endfunction
   // 8888 channel order back to argb
   function [31:0] lane(input [31:0] s, input [1:0] l);
      case (l)
         2'h0: lane = s;
         2'h1: lane = {s[31:24], s[7:0], s[15:8], s[23:16]};
         2'h2: lane = {s[7:0], s[31:8]};
         default: lane = swz(s);
      endcase
   endfunction
   // 16-bit colour as argb, bits below each channel's width left zero
   function [31:0] c16(input [15:0] d, input [3:0] f, input [1:0] l, input [7:0] ka);
      reg [4:0] p, q;
      reg [5:0] g;
      reg [7:0] a;
      begin
         a = ka;
         p = d[14:10];
         g = {d[9:5], 1'b0};
         q = d[4:0];
         if (f[1:0] == 2'h0)
         begin
            p = d[15:11];
            g = d[10:5];
         end
         else if (l[1])
         begin
            p = d[15:11];
            g = {d[10:6], 1'b0};
            q = d[5:1];
            if (f[1]) a = {8{d[0]}};
         end
         else if (f[1]) a = {8{d[15]}};
         c16 = l[0] ? {a, q, 3'h0, g, 2'h0, p, 3'h0} : {a, p, 3'h0, g, 2'h0, q, 3'h0};
      end
   endfunction
   task chk(input [63:0] nm, input [47:0] e, input [47:0] g);
      compares = compares + 1;
      if (e !== g)
      begin
         bad_count = bad_count + 1;
         $display("Error %0s expected %h seen %h", nm, e, g);
      end
   endtask
   task summarize;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // register write; bench keeps its own copy of each field
   task wreg(input [3:0] a, input [31:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      if (a == `FBHA_OFS_ACCESS_CTRL) c_q = d[16:0];
      if (a == `FBHA_OFS_PIXEL_MODE) p_q = d;
      if (a == `FBHA_OFS_CONST_DA) k_q = d;
   endtask
   task rreg(input [3:0] a, input [31:0] e);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk("reg", e, reg_rdata);
   endtask
   // one window write, beat checked in the cycle it stands
   task wpx(input [31:0] d);
      reg [3:0] f;
      reg [31:0] s, t, m;
      reg [15:0] z;
      reg pp, ab, rs;
      f = c_q[3:0];
      pp = c_q[8];
      ab = p_q[18];
      s = c_q[12] ? swz(d) : d;
      if (c_q[11] && f != 4'h4 && f != 4'h5) s = {s[15:0], s[31:16]};
      rs = f == 4'h3 || (f > 4'h5 && f < 4'hC) || c_q[5];
      z = (f == 4'hF) ? s[15:0] : (f >= 4'hC) ? s[31:16] : k_q[15:0];
      t = lane(s, c_q[10:9]);
      m = (f[1:0] == 2'h0) ? 32'hFFF8FCF8 : 32'hFFF8F8F8;
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      win_offset <= rnd[19:0];
      win_wdata <= d;
      win_wr <= 1'b1;
      @(posedge ref_clk);
      win_wr <= 1'b0;
      #1 chk("valid", !rs, px_valid_ff);
      if (rs) drops = drops + 1;
      else
      begin
         chk("xy", rnd[19:0], {px_y_ff, px_x_ff});
         chk("route", {pp, c_q[5:4], pp ? p_q[17] : c_q[13], f < 4'h3 || f == 4'hF},
             {px_to_pipe_ff, px_buf_ff, px_origin_bottom_ff, px_pair_ff});
         chk("we", pp ? 3'h7 : {f != 4'hF, f >= 4'hC && !(f == 4'hE && ab),
             (f == 4'h2 || f == 4'h5 || f == 4'hE) && ab},
             {px_col_we_ff, px_z_we_ff, px_a_we_ff});
         if (pp || (f >= 4'hC && !(f == 4'hE && ab))) chk("z0", z, px_z0_ff);
         if (f == 4'hF) chk("z1", s[31:16], px_z1_ff);
         if (pp) chk("w", {16'h0, c_q[14] ? k_q[15:0] : z, 16'h0}, px_w_ff);
         if (f == 4'h4 || f == 4'h5)
            chk("argb", {f == 4'h5 ? t[31:24] : k_q[31:24], t[23:0]}, px_argb0_ff);
         if (f == 4'h2 && pp) chk("alpha", {8{c_q[10] ? s[0] : s[15]}},
             px_argb0_ff[31:24]);
         if (f < 4'h3 || (f >= 4'hC && f != 4'hF))
            chk("col0", c16(s[15:0], f, c_q[10:9], k_q[31:24]), px_argb0_ff & m);
         if (f < 4'h3)
            chk("col1", c16(s[31:16], f, c_q[10:9], k_q[31:24]), px_argb1_ff & m);
      end
   endtask
   // window read; write swizzle bit set at random must not matter
   task rpx(input [1:0] sel, input [1:0] mode);
      reg [31:0] e;
      rnd = lfsr(rnd);
      wreg(`FBHA_OFS_ACCESS_CTRL, {15'h0, mode, 1'b0, rnd[13:12], 4'h0, sel, 6'h0});
      e = {sel, rnd[13], 1'b1, 8'hC3, rnd[29:10]};
      if (mode[0]) e = {e[15:0], e[31:16]};
      if (mode[1]) e = swz(e);
      if (sel == 2'h3) e = 32'h0;
      @(posedge ref_clk);
      win_offset <= rnd[29:10];
      win_rd <= 1'b1;
      #1 chk("rsrc", {sel, rnd[13]}, {buf_rd_src, buf_rd_origin_bottom});
      @(posedge ref_clk);
      win_rd <= 1'b0;
      #1 chk("rdata", e, win_rdata);
   endtask
   initial
   begin
      rnd = 32'h43CAEFD1;
      c_q = 17'h0;
      p_q = 32'h0;
      k_q = 32'h0;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      for (i = 0; i < 4; i = i + 1) rreg(i[3:0], 32'h0);
      wreg(4'h9, 32'hFFFFFFFF);
      rreg(`FBHA_OFS_ACCESS_CTRL, 32'h0);
      wreg(`FBHA_OFS_ACCESS_CTRL, 32'hFFFFFFFF);
      rreg(`FBHA_OFS_ACCESS_CTRL, 32'h0001FFFF);
      $display("registers done");
      wreg(`FBHA_OFS_CONST_DA, 32'h9A00BEEF);
      for (i = 0; i < 8; i = i + 1)
      begin
         wreg(`FBHA_OFS_ACCESS_CTRL, {15'h0, DC[i*17 +: 17]});
         wreg(`FBHA_OFS_PIXEL_MODE, {13'h0, ~i[0], i[1], 17'h0});
         wpx(32'h8123F00E);
      end
      // random sweep; masks in pixel mode vary too
      for (i = 0; i < 500; i = i + 1)
      begin
         rnd = lfsr(rnd);
         wreg(`FBHA_OFS_ACCESS_CTRL, {15'h0, rnd[16:6], rnd[5] & rnd[20], rnd[4:0]});
         wreg(`FBHA_OFS_PIXEL_MODE, lfsr(rnd));
         wreg(`FBHA_OFS_CONST_DA, lfsr(lfsr(rnd)));
         wpx(rnd ^ 32'h5A3C96E1);
      end
      $display("pixel writes done");
      for (i = 0; i < 16; i = i + 1) rpx(i[1:0], i[3:2]);
      $display("window reads done");
      wreg(`FBHA_OFS_ACCESS_CTRL, 32'h0);
      rreg(`FBHA_OFS_STATUS, {24'h0, drops > 255 ? 8'hFF : drops[7:0]});
      summarize;
   end
endmodule // tb_fbha_top
